// [design/dpi_host_slave.sv]
// host slave port: address match, byte/ack handling, clock stretch, strap address
`timescale 1ns/1ps
`include "dpi_params.svh"
////////////////////////////////////////////////////////////////////////////////
// Behaviour
// - matched address acked low on ninth clock
// - sda changes only while scl low
// - eight data bits then one ack
// - transmitter releases sda before ack clock
// - slave receiver acks every byte
// - nack on last read, slave releases
// - slave may stretch scl after byte
// - address 0100, port bit, strap index
// - index from strap decoded values at startup
// - loader mode answers port a only
// - second port addresses from configuration
// - master port reads memory at 0x50
// - master port is sole bus master
// - sub-address byte selects command
// - per-port interrupt output or gpo; alert mode drives both pins from req a or req b
// - open-drain drive, de-glitched inputs
module dpi_host_slave
#(
    parameter int STRETCH_CYC = `DPI_STRETCH_CYC // cycles scl held low after each ack
)
(
    input wire logic i_clk_sys, // system clock 200 MHz
    input wire logic i_sys_rst, // synchronous reset, active high
    input wire logic i_scl, // scl line level
    input wire logic i_sda, // sda line level
    output logic o_scl_oe, // pull scl low when high
    output logic o_sda_oe, // pull sda low when high
    input wire logic [2:0] i_strap_one_code, // decoded strap_pin_one value
    input wire logic [2:0] i_strap_two_code, // decoded strap_pin_two value
    input wire logic i_strap_valid, // strap codes are settled
    input wire logic i_startup_done, // leaves loader, enters application_mode
    input wire logic i_irq_req_a, // port a alert request
    input wire logic i_irq_req_b, // port b alert request
    input wire logic i_irq_gpo_mode, // interrupts used as plain outputs
    input wire logic [1:0] i_gpo_val, // gpo values for host and second port
    input wire logic [7:0] i_tx_data, // byte to send on read
    output logic [7:0] o_rx_data, // received byte
    output logic o_rx_valid, // pulse: o_rx_data new
    output logic o_rx_is_sub, // received byte is the sub-address
    output logic o_tx_take, // pulse: i_tx_data consumed
    output logic o_port_sel, // addressed port, 0 a 1 b
    output logic o_rd_mode, // current transfer is a read
    output logic [7:0] o_sub_addr, // command sub-address
    output logic o_busy, // inside a frame
    output logic [1:0] o_addr_index, // latched strap index
    output logic o_index_valid, // strap index latched
    output logic o_app_mode, // application_mode flag
    output logic o_host_port_interrupt, // host_port_interrupt pin, active low
    output logic o_second_port_interrupt // second_port_interrupt pin, active low
);
    import dpi_pkg::*;

    logic scl_lvl, scl_rise, scl_fall;
    logic sda_lvl, sda_rise, sda_fall;
    dpi_state_t state_ff;
    logic [7:0] shift_ff;
    logic [3:0] bit_cnt_ff;
    logic first_byte_ff;
    logic [$clog2(STRETCH_CYC+1)-1:0] stretch_cnt_ff;
    dpi_mode_t mode_ff;

    dpi_sync u_scl_sync (
        .i_clk_sys(i_clk_sys),
        .i_sys_rst(i_sys_rst),
        .i_line(i_scl),
        .o_level(scl_lvl),
        .o_rise(scl_rise),
        .o_fall(scl_fall)
    );
    dpi_sync u_sda_sync (
        .i_clk_sys(i_clk_sys),
        .i_sys_rst(i_sys_rst),
        .i_line(i_sda),
        .o_level(sda_lvl),
        .o_rise(sda_rise),
        .o_fall(sda_fall)
    );

    // control conditions: sda moves while scl high
    wire start_cond = sda_fall && scl_lvl;
    wire stop_cond = sda_rise && scl_lvl;

    // strap table: codes to index, 2'h0 default when no match
    function automatic logic [1:0] strap_index(input logic [2:0] a, input logic [2:0] b);
        case ({a, b})
            {3'h7, 3'h5}, {3'h7, 3'h4}, {3'h7, 3'h6}, {3'h7, 3'h3}, {3'h7, 3'h0}: strap_index = 2'h0;
            {3'h5, 3'h5}, {3'h4, 3'h4}, {3'h6, 3'h6}, {3'h3, 3'h3}, {3'h0, 3'h0}: strap_index = 2'h1;
            {3'h2, 3'h0}, {3'h3, 3'h0}, {3'h6, 3'h5}, {3'h4, 3'h0}, {3'h6, 3'h0}: strap_index = 2'h2;
            {3'h1, 3'h7}, {3'h2, 3'h7}, {3'h6, 3'h7}, {3'h3, 3'h7}, {3'h5, 3'h7}: strap_index = 2'h3;
            default: strap_index = 2'h0;
        endcase
    endfunction
    // address check: 0100 upper, port bit, index bits
    function automatic logic addr_hit(input logic [6:0] a, input logic [1:0] idx, input logic pb);
        addr_hit = (a[6:3] == `DPI_ADDR_UPPER) && (a[2] == pb) && (a[1:0] == idx);
    endfunction
    ////////////////////////////////////////////////////////////////////////////
    // strap capture and mode
    always_ff @(posedge i_clk_sys)
    begin
        if (i_sys_rst)
        begin
            o_addr_index <= 2'h0;
            o_index_valid <= 1'b0;
        end
        else if (i_strap_valid && !o_index_valid)
        begin
            o_addr_index <= strap_index(i_strap_one_code, i_strap_two_code);
            o_index_valid <= 1'b1;
        end
    end

    // port b only opens after startup completes
    always_ff @(posedge i_clk_sys)
    begin
        if (i_sys_rst)
            mode_ff <= DPI_MODE_LOADER;
        else if (i_startup_done && o_index_valid)
            mode_ff <= DPI_MODE_APP;
    end
    always_ff @(posedge i_clk_sys)
    begin
        if (i_sys_rst)
            o_app_mode <= 1'b0;
        else
            o_app_mode <= (mode_ff == DPI_MODE_APP);
    end
    wire [6:0] rx_addr = shift_ff[7:1];
    wire hit_a = o_index_valid && addr_hit(rx_addr, o_addr_index, 1'b0);
    wire hit_b = o_index_valid && (mode_ff == DPI_MODE_APP) && addr_hit(rx_addr, o_addr_index, 1'b1);
    ////////////////////////////////////////////////////////////////////////////
    // frame state machine, sampling on scl rise, driving on scl fall
    always_ff @(posedge i_clk_sys)
    begin
        if (i_sys_rst)
        begin
            state_ff <= DPI_IDLE;
            shift_ff <= 8'h00;
            bit_cnt_ff <= 4'h0;
            first_byte_ff <= 1'b0;
            o_sda_oe <= 1'b0;
            o_port_sel <= 1'b0;
            o_rd_mode <= 1'b0;
            o_rx_valid <= 1'b0;
            o_rx_data <= 8'h00;
            o_rx_is_sub <= 1'b0;
            o_tx_take <= 1'b0;
            o_sub_addr <= 8'h00;
        end
        else
        begin
            o_rx_valid <= 1'b0;
            o_tx_take <= 1'b0;
            if (start_cond)
            begin
                state_ff <= DPI_ADDR;
                bit_cnt_ff <= 4'h0;
                o_sda_oe <= 1'b0;
            end
            else if (stop_cond)
            begin
                state_ff <= DPI_IDLE;
                o_sda_oe <= 1'b0;
            end
            else
            begin
                case (state_ff)
                    DPI_ADDR, DPI_RX:
                    begin
                        if (scl_rise)
                        begin
                            shift_ff <= {shift_ff[6:0], sda_lvl};
                            bit_cnt_ff <= bit_cnt_ff + 4'h1;
                        end
                        else if (scl_fall && bit_cnt_ff == `DPI_BITS_PER_BYTE)
                        begin
                            bit_cnt_ff <= 4'h0;
                            if (state_ff == DPI_ADDR)
                            begin
                                if (hit_a || hit_b)
                                begin
                                    o_sda_oe <= 1'b1;
                                    o_port_sel <= hit_b;
                                    o_rd_mode <= shift_ff[0];
                                    first_byte_ff <= ~shift_ff[0];
                                    state_ff <= DPI_ADDR_ACK;
                                end
                                else
                                    state_ff <= DPI_IGNORE;
                            end
                            else
                            begin
                                o_sda_oe <= 1'b1;
                                o_rx_data <= shift_ff;
                                o_rx_is_sub <= first_byte_ff;
                                o_rx_valid <= 1'b1;
                                if (first_byte_ff)
                                    o_sub_addr <= shift_ff;
                                first_byte_ff <= 1'b0;
                                state_ff <= DPI_RX_ACK;
                            end
                        end
                    end
                    DPI_ADDR_ACK, DPI_RX_ACK:
                        if (scl_fall)
                        begin
                            if (o_rd_mode)
                            begin
                                o_sda_oe <= ~i_tx_data[7];
                                shift_ff <= {i_tx_data[6:0], 1'b1};
                                o_tx_take <= 1'b1;
                                bit_cnt_ff <= 4'h1;
                                state_ff <= DPI_TX;
                            end
                            else
                            begin
                                o_sda_oe <= 1'b0;
                                state_ff <= DPI_RX;
                            end
                        end
                    DPI_TX:
                        if (scl_fall)
                        begin
                            if (bit_cnt_ff == `DPI_BITS_PER_BYTE)
                            begin
                                o_sda_oe <= 1'b0;
                                state_ff <= DPI_TX_ACK;
                            end
                            else
                            begin
                                o_sda_oe <= ~shift_ff[7];
                                shift_ff <= {shift_ff[6:0], 1'b1};
                                bit_cnt_ff <= bit_cnt_ff + 4'h1;
                            end
                        end
                    DPI_TX_ACK:
                        if (scl_rise)
                            state_ff <= sda_lvl ? DPI_IGNORE : DPI_ADDR_ACK;
                    DPI_IGNORE, DPI_IDLE:
                        o_sda_oe <= 1'b0;
                    default:
                        state_ff <= DPI_IDLE;
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // stretch scl low after each ack clock so the core can take/give data
    wire ack_end = scl_fall && (state_ff == DPI_ADDR_ACK || state_ff == DPI_RX_ACK);
    always_ff @(posedge i_clk_sys)
    begin
        if (i_sys_rst || start_cond || stop_cond)
            stretch_cnt_ff <= '0;
        else if (ack_end)
            stretch_cnt_ff <= ($clog2(STRETCH_CYC+1))'(STRETCH_CYC);
        else if (stretch_cnt_ff != '0)
            stretch_cnt_ff <= stretch_cnt_ff - 1'b1;
    end
    always_ff @(posedge i_clk_sys)
    begin
        if (i_sys_rst)
            o_scl_oe <= 1'b0;
        else
            o_scl_oe <= ack_end || (stretch_cnt_ff > 1);
    end

    always_ff @(posedge i_clk_sys)
    begin
        if (i_sys_rst)
            o_busy <= 1'b0;
        else
            o_busy <= (state_ff != DPI_IDLE);
    end

    // interrupt pins: active-low alert or plain output
    always_ff @(posedge i_clk_sys)
    begin
        if (i_sys_rst)
        begin
            o_host_port_interrupt <= 1'b1;
            o_second_port_interrupt <= 1'b1;
        end
        else if (i_irq_gpo_mode)
        begin
            o_host_port_interrupt <= i_gpo_val[0];
            o_second_port_interrupt <= i_gpo_val[1];
        end
        else
        begin
            o_host_port_interrupt <= ~(i_irq_req_a | i_irq_req_b);
            o_second_port_interrupt <= ~(i_irq_req_a | i_irq_req_b);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    AST_NOACK_UNMATCHED: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
        state_ff == DPI_IGNORE |-> ##1 !o_sda_oe || start_cond)
        else $error("sda driven while ignoring");
    AST_PORTB_LOADER: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
        (mode_ff == DPI_MODE_LOADER && state_ff == DPI_ADDR_ACK) |-> !o_port_sel)
        else $error("port b answered in loader mode");
    AST_ACK_ON_MATCH: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
        (state_ff == DPI_ADDR && scl_fall && bit_cnt_ff == 4'h8 && hit_a && !start_cond && !stop_cond)
        |=> o_sda_oe && state_ff == DPI_ADDR_ACK)
        else $error("matched address not acked");
    AST_RX_ACK: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
        state_ff == DPI_RX_ACK |-> o_sda_oe)
        else $error("received byte not acked");
    AST_RELEASE_TX_ACK: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
        state_ff == DPI_TX_ACK |-> !o_sda_oe)
        else $error("sda held in read ack slot");
    AST_SDA_SCL_LOW: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
        ($changed(o_sda_oe) && !$past(start_cond) && !$past(stop_cond)) |-> $past(scl_fall))
        else $error("sda moved outside scl fall");
    AST_STRETCH_LEN: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
        (ack_end && !start_cond && !stop_cond) |=> o_scl_oe [*2])
        else $error("scl stretch too short");
    AST_NACK_END: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
        (state_ff == DPI_TX_ACK && scl_rise && sda_lvl && !start_cond && !stop_cond)
        |=> state_ff == DPI_IGNORE ##1 !o_sda_oe)
        else $error("slave kept sda after nack");
endmodule

// [design/dpi_params.svh]
// timing counts and address fields for the host slave port
`ifndef DPI_PARAMS_SVH
`define DPI_PARAMS_SVH
`define DPI_ADDR_UPPER 4'h4
`define DPI_ADDR_PORT_BIT 3
`define DPI_ADDR_IDX_LSB 1
`define DPI_EEPROM_ADDR 7'h50
// boot memory reader, sole-master port and second-port address table sit in another block
`define DPI_BITS_PER_BYTE 4'h8
`define DPI_CLK_PERIOD_NS 5
`define DPI_STRETCH_NS 1000
`define DPI_STRETCH_CYC ((`DPI_STRETCH_NS + `DPI_CLK_PERIOD_NS - 1) / `DPI_CLK_PERIOD_NS)
`define DPI_MHALF_NS 5000
`define DPI_MHALF_CYC (`DPI_MHALF_NS / `DPI_CLK_PERIOD_NS)
`endif

// [design/dpi_pkg.sv]
// frame state and mode types used by the host slave port
package dpi_pkg;
    typedef enum logic [2:0] {
        DPI_IDLE,
        DPI_ADDR,
        DPI_ADDR_ACK,
        DPI_RX,
        DPI_RX_ACK,
        DPI_TX,
        DPI_TX_ACK,
        DPI_IGNORE
    } dpi_state_t;
    typedef enum logic [1:0] {
        DPI_MODE_LOADER,
        DPI_MODE_APP
    } dpi_mode_t;
endpackage

// [design/dpi_sync.sv]
// three-stage synchroniser with agreement filter for an open-drain line input
`timescale 1ns/1ps
module dpi_sync
(
    input wire logic i_clk_sys, // system clock
    input wire logic i_sys_rst, // synchronous reset
    input wire logic i_line, // raw line level
    output logic o_level, // filtered level
    output logic o_rise, // one-cycle rising event
    output logic o_fall // one-cycle falling event
);
    logic meta_ff;
    logic s2_ff;
    logic s3_ff;

    // lines idle high, so reset to high
    always_ff @(posedge i_clk_sys)
    begin
        if (i_sys_rst)
        begin
            meta_ff <= 1'b1;
            s2_ff <= 1'b1;
            s3_ff <= 1'b1;
        end
        else
        begin
            meta_ff <= i_line;
            s2_ff <= meta_ff;
            s3_ff <= s2_ff;
        end
    end

    // change is taken only once stages two and three agree
    always_ff @(posedge i_clk_sys)
    begin
        if (i_sys_rst)
        begin
            o_level <= 1'b1;
            o_rise <= 1'b0;
            o_fall <= 1'b0;
        end
        else
        begin
            o_rise <= 1'b0;
            o_fall <= 1'b0;
            if (s2_ff == s3_ff && s3_ff != o_level)
            begin
                o_level <= s3_ff;
                o_rise <= s3_ff;
                o_fall <= ~s3_ff;
            end
        end
    end
endmodule

// [verif/dpi_mst_model.sv]
// bit-level model of the far-side bus master for the host slave port
`timescale 1ns/1ps
module dpi_mst_model
#(
    parameter int HALF_NS = 32, // low phase of the link clock, about 49 ns with HIGH_NS, rate scaled up for simulation
    parameter int HIGH_NS = 16 // minimum high time, scaled down for simulation
)
(
    input wire logic i_scl, // scl wire level
    input wire logic i_sda, // sda wire level
    output logic o_scl_oe, // pulls scl low when high
    output logic o_sda_oe // pulls sda low when high
);
    int stretch_seen = 0;
    initial o_scl_oe = 1'b0;
    initial o_sda_oe = 1'b0;
    ////////////////////////////////////////////////////////////////////////////////
    // released scl may still be held low by a stretching slave
    task automatic clk_high();
        o_scl_oe = 1'b0;
        #1;
        if (i_scl !== 1'b1)
            stretch_seen++;
        wait (i_scl === 1'b1);
        #(HIGH_NS);
    endtask
    // sda moves early in the low phase; sampled at the end of the high phase
    task automatic put_bit(input logic b, output logic s);
        #8;
        o_sda_oe = ~b;
        #(HALF_NS - 8);
        clk_high();
        s = i_sda;
        o_scl_oe = 1'b1;
    endtask
    task automatic start();
        if (o_scl_oe)
        begin
            #8;
            o_sda_oe = 1'b0;
            #(HALF_NS - 8);
            clk_high();
        end
        wait (i_scl === 1'b1 && i_sda === 1'b1);
        o_sda_oe = 1'b1;
        #(HALF_NS);
        o_scl_oe = 1'b1;
    endtask
    task automatic stop();
        #8;
        o_sda_oe = 1'b1;
        #(HALF_NS - 8);
        clk_high();
        o_sda_oe = 1'b0;
        #(HALF_NS);
    endtask
    task automatic write_byte(input logic [7:0] d, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--)
            put_bit(d[i], s);
        put_bit(1'b1, s);
        ack = ~s;
    endtask
    // last byte gets a nack; the wire level in that slot is handed back
    task automatic read_byte(input logic last, output logic [7:0] d, output logic ack_line);
        logic s;
        for (int i = 7; i >= 0; i--)
        begin
            put_bit(1'b1, s);
            d[i] = s;
        end
        put_bit(last, ack_line);
    endtask
endmodule

// [verif/tb_dpi_host_slave.sv]
// self-checking bench: host slave port against a bit-level master model
`timescale 1ns/1ps
module tb_dpi_host_slave;
    localparam int STRETCH = 8;
    localparam int LIMIT = 20000;
    localparam logic [2:0] S1 [5] = '{3'h7, 3'h5, 3'h2, 3'h1, 3'h1};
    localparam logic [2:0] S2 [5] = '{3'h5, 3'h5, 3'h0, 3'h7, 3'h1};
    localparam logic [1:0] IDX [5] = '{2'h0, 2'h1, 2'h2, 2'h3, 2'h0};
    // req a, req b, gpo mode, gpo value, expected host and second pins
    localparam logic [6:0] IRQ_TAB [5] = '{7'h03, 7'h40, 7'h20, 7'h76, 7'h19};
    logic i_clk_sys, i_sys_rst, i_strap_valid, i_startup_done;
    logic i_irq_req_a, i_irq_req_b, i_irq_gpo_mode;
    logic [2:0] i_strap_one_code, i_strap_two_code;
    logic [1:0] i_gpo_val, o_addr_index;
    logic [7:0] i_tx_data, o_rx_data, o_sub_addr, rx_last;
    logic o_scl_oe, o_sda_oe, o_rx_valid, o_rx_is_sub, o_tx_take, o_port_sel, o_rd_mode;
    logic o_busy, o_index_valid, o_app_mode, o_host_port_interrupt, o_second_port_interrupt;
    logic m_scl_oe, m_sda_oe, scl_w, sda_w;
    int err_count = 0;
    int comparisons = 0;
    int rx_cnt = 0;
    int oe_cnt = 0;
    int cycles = 0;
    // open-drain wires with pull-ups
    assign scl_w = ~(o_scl_oe | m_scl_oe);
    assign sda_w = ~(o_sda_oe | m_sda_oe);
    dpi_host_slave #(.STRETCH_CYC(STRETCH)) dpi_host_slave_i (
        .i_clk_sys(i_clk_sys), .i_sys_rst(i_sys_rst), .i_scl(scl_w), .i_sda(sda_w),
        .o_scl_oe(o_scl_oe), .o_sda_oe(o_sda_oe), .i_strap_one_code(i_strap_one_code),
        .i_strap_two_code(i_strap_two_code), .i_strap_valid(i_strap_valid), .i_startup_done(i_startup_done),
        .i_irq_req_a(i_irq_req_a), .i_irq_req_b(i_irq_req_b), .i_irq_gpo_mode(i_irq_gpo_mode),
        .i_gpo_val(i_gpo_val), .i_tx_data(i_tx_data), .o_rx_data(o_rx_data), .o_rx_valid(o_rx_valid),
        .o_rx_is_sub(o_rx_is_sub), .o_tx_take(o_tx_take), .o_port_sel(o_port_sel), .o_rd_mode(o_rd_mode),
        .o_sub_addr(o_sub_addr), .o_busy(o_busy), .o_addr_index(o_addr_index), .o_index_valid(o_index_valid),
        .o_app_mode(o_app_mode), .o_host_port_interrupt(o_host_port_interrupt),
        .o_second_port_interrupt(o_second_port_interrupt));
    dpi_mst_model dpi_mst_model_i (.i_scl(scl_w), .i_sda(sda_w), .o_scl_oe(m_scl_oe), .o_sda_oe(m_sda_oe));
    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        i_clk_sys = 1'b0;
        forever #2.5 i_clk_sys = ~i_clk_sys;
    end
    // rx_valid is a one-cycle pulse, so it is caught here rather than polled
    always @(posedge i_clk_sys)
    begin
        cycles <= cycles + 1;
        if (o_rx_valid === 1'b1)
        begin
            rx_cnt <= rx_cnt + 1;
            rx_last <= o_rx_data;
        end
        if (o_scl_oe === 1'b1)
            oe_cnt <= oe_cnt + 1;
        if (o_tx_take === 1'b1)
            i_tx_data <= i_tx_data + 8'h11;
        if (cycles == LIMIT)
        begin
            err_count++;
            $display("unexpected at %0t: run did not finish in time", $time);
            give_verdict();
        end
    end
    task automatic check_bit(input logic got, input logic exp);
        comparisons++;
        if (got !== exp)
        begin
            err_count++;
            $display("unexpected at %0t: bit %b, wanted %b", $time, got, exp);
        end
    endtask
    task automatic check_byte(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            err_count++;
            $display("unexpected at %0t: byte %h, wanted %h", $time, got, exp);
        end
    endtask
    task automatic give_verdict();
        $display("comparisons %0d, mismatches %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    task automatic do_reset(input logic [2:0] s1, input logic [2:0] s2);
        @(posedge i_clk_sys);
        i_sys_rst <= 1'b1;
        i_strap_valid <= 1'b0;
        i_startup_done <= 1'b0;
        i_strap_one_code <= s1;
        i_strap_two_code <= s2;
        repeat (10) @(posedge i_clk_sys);
        i_sys_rst <= 1'b0;
        repeat (4) @(posedge i_clk_sys);
    endtask
    task automatic addr(input logic [6:0] a, input logic rw, input logic exp);
        logic ack;
        dpi_mst_model_i.start();
        dpi_mst_model_i.write_byte({a, rw}, ack);
        check_bit(ack, exp);
    endtask
    task automatic wr(input logic [7:0] d, input logic exp);
        logic ack;
        dpi_mst_model_i.write_byte(d, ack);
        check_bit(ack, exp);
    endtask
    // one strap pair per index plus an unmatched pair, refusals before the index is latched and on port b in loader mode
    task automatic t_straps();
        for (int k = 0; k < 5; k++)
        begin
            do_reset(S1[k], S2[k]);
            addr(7'h20, 1'b0, 1'b0);
            dpi_mst_model_i.stop();
            @(posedge i_clk_sys);
            i_strap_valid <= 1'b1;
            repeat (3) @(posedge i_clk_sys);
            check_byte({5'h00, o_index_valid, o_addr_index}, {5'h00, 1'b1, IDX[k]});
            addr({4'h4, 1'b0, IDX[k]}, 1'b0, 1'b1);
            dpi_mst_model_i.stop();
            addr({4'h4, 1'b1, IDX[k]}, 1'b0, 1'b0);
            dpi_mst_model_i.stop();
        end
    endtask
    task automatic t_write();
        int n0;
        int o0;
        int s0;
        n0 = rx_cnt;
        o0 = oe_cnt;
        s0 = dpi_mst_model_i.stretch_seen;
        addr(7'h20, 1'b0, 1'b1);
        wr(8'h5A, 1'b1);
        check_bit(o_rx_is_sub, 1'b1);
        wr(8'hC3, 1'b1);
        check_bit(o_rx_is_sub, 1'b0);
        wr(8'h00, 1'b1);
        repeat (2) @(posedge i_clk_sys);
        check_byte(rx_last, 8'h00);
        check_byte(8'(rx_cnt - n0), 8'h03);
        check_byte(o_sub_addr, 8'h5A);
        check_byte({5'h00, o_port_sel, o_rd_mode, o_busy}, 8'h01);
        check_bit(dpi_mst_model_i.stretch_seen > s0, 1'b1);
        dpi_mst_model_i.stop();
        repeat (6) @(posedge i_clk_sys);
        check_byte(8'(oe_cnt - o0), 8'(4 * STRETCH));
        check_bit(o_busy, 1'b0);
    endtask
    // port b in application mode: sub-address, repeated start, two-byte read
    task automatic t_read();
        logic [7:0] d;
        logic al;
        @(posedge i_clk_sys);
        i_startup_done <= 1'b1;
        repeat (4) @(posedge i_clk_sys);
        check_bit(o_app_mode, 1'b1);
        addr(7'h24, 1'b0, 1'b1);
        wr(8'h10, 1'b1);
        addr(7'h24, 1'b1, 1'b1);
        dpi_mst_model_i.read_byte(1'b0, d, al);
        check_byte(d, 8'hA5);
        dpi_mst_model_i.read_byte(1'b1, d, al);
        check_byte(d, 8'hB6);
        check_bit(al, 1'b1);
        check_byte(o_sub_addr, 8'h10);
        check_byte({6'h00, o_port_sel, o_rd_mode}, 8'h03);
        dpi_mst_model_i.stop();
    endtask
    task automatic t_mismatch();
        int n0;
        addr(7'h50, 1'b0, 1'b0);
        n0 = rx_cnt;
        wr(8'h77, 1'b0);
        dpi_mst_model_i.stop();
        addr(7'h25, 1'b0, 1'b0);
        dpi_mst_model_i.stop();
        repeat (4) @(posedge i_clk_sys);
        check_byte(8'(rx_cnt - n0), 8'h00);
    endtask
    task automatic t_irq();
        for (int k = 0; k < 5; k++)
        begin
            @(posedge i_clk_sys);
            {i_irq_req_a, i_irq_req_b, i_irq_gpo_mode, i_gpo_val} <= IRQ_TAB[k][6:2];
            repeat (3) @(posedge i_clk_sys);
            check_byte({6'h00, o_host_port_interrupt, o_second_port_interrupt}, {6'h00, IRQ_TAB[k][1:0]});
        end
    endtask
    initial
    begin
        i_sys_rst = 1'b1;
        {i_strap_valid, i_startup_done, i_irq_req_a, i_irq_req_b, i_irq_gpo_mode} = 5'h00;
        {i_strap_one_code, i_strap_two_code, i_gpo_val} = 8'h00;
        i_tx_data = 8'hA5;
        do_reset(3'h7, 3'h5);
        check_bit(o_scl_oe | o_sda_oe, 1'b0);
        check_bit(o_host_port_interrupt & o_second_port_interrupt, 1'b1);
        check_bit(o_index_valid | o_app_mode, 1'b0);
        t_straps();
        t_write();
        t_read();
        t_mismatch();
        t_irq();
        give_verdict();
    end
endmodule
